// file: rtl/bank_pkg.sv
// Constants and register map for the split output bank block
`default_nettype none
package bank_pkg;
    // Clock and timing
    localparam int unsigned CLK_HZ            = 20_000_000;
    localparam int unsigned CYC_PER_US        = CLK_HZ / 1_000_000;
    localparam int unsigned WD_TIME_US        = 327_000;
    localparam int unsigned WD_TOL_US         = 16_000;
    localparam int unsigned WD_CYCLES         = WD_TIME_US * CYC_PER_US;
    localparam int unsigned EXT_RST_TIME_US   = 90_000;
    localparam int unsigned EXT_RST_CYCLES    = EXT_RST_TIME_US * CYC_PER_US;
    localparam int unsigned STROBE_TIME_NS    = 2_000;
    // Scaled through cycles per microsecond so the product stays inside 32 bits
    localparam int unsigned STROBE_CYCLES     = (STROBE_TIME_NS * CYC_PER_US + 999) / 1000;
    localparam int unsigned CYCLE_STD_MS      = 5;
    localparam int unsigned CYCLE_EXT_MS      = 10;
    localparam logic [7:0]  STROBE_LOAD       = 8'(STROBE_CYCLES);
    // Register byte offsets
    localparam logic [7:0]  CTRL_OFS          = 8'h00;
    localparam logic [7:0]  STATUS_OFS        = 8'h04;
    localparam logic [7:0]  ACTIVATE_OFS      = 8'h08;
    localparam logic [7:0]  IRQ_STATUS_OFS    = 8'h0c;
    localparam logic [7:0]  IRQ_CLEAR_OFS     = 8'h10;
    localparam logic [7:0]  IRQ_ENABLE_OFS    = 8'h14;
    // Control register fields
    localparam int unsigned CTRL_EXT_MODE     = 0;
    localparam int unsigned CTRL_SPLIT        = 1;
    localparam int unsigned CTRL_JOINT        = 2;
    localparam int unsigned CTRL_COMM_WD      = 3;
    localparam int unsigned CTRL_NVM_BUSY     = 4;
    localparam int unsigned CTRL_AB_SEL       = 5;
    localparam int unsigned CTRL_ADDR_LSB     = 8;
    localparam logic [12:0] CTRL_RESET        = 13'h0000;
    // Interrupt event bits
    localparam int unsigned IRQ_OUT_EVENT     = 0;
    localparam int unsigned IRQ_WD_EXPIRE     = 1;
    localparam int unsigned IRQ_EXT_RESET     = 2;
    localparam int unsigned IRQ_CALL          = 3;
    localparam int unsigned IRQ_W             = 4;
    // Inactive data output level
    localparam logic [3:0]  DATA_IDLE         = 4'h0;
    // Watchdog sequencer states
    typedef enum logic [1:0] {
        ST_RUN    = 2'b00,
        ST_STROBE = 2'b01,
        ST_RESET  = 2'b10
    } wd_state_type;
endpackage
`default_nettype wire

// file: rtl/sync2.sv
// Two flip-flop synchroniser for pin inputs
`default_nettype none
module sync2 #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_r <= '0;
            q_r    <= '0;
        end else begin
            meta_r <= d_in;
            q_r    <= meta_r;
        end
    end

    assign q_out = q_r;
endmodule
`default_nettype wire

// file: rtl/hold_timer.sv
// Counter that flags when a condition has run for LIMIT + 1 cycles
`default_nettype none
module hold_timer #(
    parameter int unsigned LIMIT = 4
) (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic run_in,
    input  wire logic restart_in,
    output logic      expired_out
);
    localparam int unsigned W = $clog2(LIMIT + 1);
    logic [W-1:0] count_r;
    logic [W-1:0] count_nxt;
    logic         expired_r;
    logic         expired_nxt;

    // Count while running; saturate and flag at the limit
    always_comb begin
        count_nxt   = count_r;
        expired_nxt = expired_r;
        if (restart_in || !run_in) begin
            count_nxt   = '0;
            expired_nxt = 1'b0;
        end else if (count_r == W'(LIMIT)) begin
            expired_nxt = 1'b1;
        end else begin
            count_nxt = count_r + W'(1);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_r   <= '0;
            expired_r <= 1'b0;
        end else begin
            count_r   <= count_nxt;
            expired_r <= expired_nxt;
        end
    end

    // Gated by run so a flag left from a dropped condition cannot fire late
    assign expired_out = expired_r && run_in;
endmodule
`default_nettype wire

// file: rtl/ext_addr_split_output_bank.sv
// Split output bank slave logic with alternation watchdog and strobe reset
// Function
// R1: I3 selects A or B slave
// R2: Without split, only three output bits used
// R3: Response always carries four input bits
// R4: Split mode: I2 high to D0/D1, low D2/D3
// R5: Master toggles I2 between consecutive calls
// R6: Output event updates ports and pulses strobe
// R7: Joint update: event only when I2 low
// R8: Joint, I2 high: hold bits, outputs unchanged
// R9: Separate update: event every call, one bank
// R10: Watchdog armed only under all enable conditions
// R11: Watchdog expiry first pulses data, parameter strobes
// R12: Then reset, set inhibit, outputs inactive
// R13: Inputs sampled and returned every call
// R14: Strobe pin low too long resets device
// R15: External reset needs strobe low over 90ms
// R16: Watchdog restarts on each I2 change
`default_nettype none
module ext_addr_split_output_bank
    import bank_pkg::*;
#(
    parameter int unsigned WD_LIMIT  = bank_pkg::WD_CYCLES,
    parameter int unsigned EXT_LIMIT = bank_pkg::EXT_RST_CYCLES
) (
    // Clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        rst_n_in,
    // Wishbone slave
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [7:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic      [31:0] wb_dat_out,
    output logic             wb_ack_out,
    // Decoded data exchange call from the link receiver
    input  wire logic        call_valid_in,
    input  wire logic [3:0]  call_info_in,
    // Slave response to the link transmitter
    output logic             resp_valid_out,
    output logic      [3:0]  resp_data_out,
    // Data port pins
    input  wire logic [3:0]  data_in_in,
    output logic      [3:0]  data_out_out,
    // Data strobe pin, open drain, also external reset input
    input  wire logic        data_strobe_n_in,
    output logic             data_strobe_n_out,
    output logic             data_strobe_oe_n_out,
    // Parameter strobe pin
    output logic             param_strobe_n_out,
    // State machine initialisation request and interrupt
    output logic             nvm_readout_out,
    output logic             irq_out
);
    logic [3:0]   din_sync;
    logic         strobe_pin_sync;
    logic         wd_expired;
    logic         ext_expired;
    logic [12:0]  ctrl_r,       ctrl_nxt;
    logic         inhibit_r,    inhibit_nxt;
    logic [3:0]   data_r,       data_nxt;
    logic [1:0]   held_r,       held_nxt;
    logic         last_i2_r,    last_i2_nxt;
    logic         resp_v_r,     resp_v_nxt;
    logic [3:0]   resp_d_r,     resp_d_nxt;
    logic [7:0]   stb_cnt_r,    stb_cnt_nxt;
    logic         dstb_r,       dstb_nxt;
    logic         pstb_r,       pstb_nxt;
    logic         nvm_r,        nvm_nxt;
    wd_state_type wd_st_r,      wd_st_nxt;
    logic [IRQ_W-1:0] irq_st_r, irq_st_nxt;
    logic [IRQ_W-1:0] irq_en_r, irq_en_nxt;
    logic         irq_r,        irq_nxt;
    logic         ack_r,        ack_nxt;
    logic [31:0]  rdat_r,       rdat_nxt;
    logic         ext_mode, split, joint, i2, accept, out_event, armed;
    logic         i2_change, soft_reset, wb_req, wb_wr;
    logic [IRQ_W-1:0] irq_ev, irq_clr;

    // Pins from outside the clock domain
    sync2 #(.W(4)) u_din_sync (
        .clk_in   (core_clk_in),
        .rst_n_in (rst_n_in),
        .d_in     (data_in_in),
        .q_out    (din_sync)
    );
    sync2 #(.W(1)) u_stb_sync (
        .clk_in   (core_clk_in),
        .rst_n_in (rst_n_in),
        .d_in     (data_strobe_n_in),
        .q_out    (strobe_pin_sync)
    );

    // Mode decode
    assign ext_mode = ctrl_r[CTRL_EXT_MODE];
    assign split    = ext_mode & ctrl_r[CTRL_SPLIT];
    assign joint    = ctrl_r[CTRL_JOINT];
    assign i2       = call_info_in[2];

    // R1: A/B slave match
    assign accept = call_valid_in && !inhibit_r && (wd_st_r == ST_RUN)
                    && (!ext_mode || (call_info_in[3] == ctrl_r[CTRL_AB_SEL]));

    // R7: joint mode fires only on I2 low
    assign out_event = accept && !(split && joint && i2);

    // R10: watchdog arming conditions
    assign armed = ctrl_r[CTRL_COMM_WD] && split && !inhibit_r
                   && (ctrl_r[CTRL_ADDR_LSB +: 5] != 5'h00) && !ctrl_r[CTRL_NVM_BUSY];

    // R16: restart on a call whose I2 differs from the last one
    assign i2_change = accept && split && (i2 != last_i2_r);

    // R11: alternation watchdog timer
    hold_timer #(.LIMIT(WD_LIMIT)) u_wd_timer (
        .clk_in      (core_clk_in),
        .rst_n_in    (rst_n_in),
        .run_in      (armed && (wd_st_r == ST_RUN)),
        .restart_in  (i2_change),
        .expired_out (wd_expired)
    );

    // R14: pin held low by someone else, not by our own strobe
    hold_timer #(.LIMIT(EXT_LIMIT)) u_ext_timer (
        .clk_in      (core_clk_in),
        .rst_n_in    (rst_n_in),
        .run_in      (!strobe_pin_sync && !dstb_r),
        .restart_in  (1'b0),
        .expired_out (ext_expired)
    );

    // R12: device reset from watchdog end or external request
    assign soft_reset = (wd_st_r == ST_RESET) || ext_expired;

    // Data path, held bits and response
    always_comb begin
        data_nxt    = data_r;
        held_nxt    = held_r;
        last_i2_nxt = last_i2_r;
        resp_v_nxt  = 1'b0;
        resp_d_nxt  = resp_d_r;
        if (soft_reset) begin
            data_nxt    = DATA_IDLE;
            held_nxt    = 2'b00;
            last_i2_nxt = 1'b0;
        end else if (accept) begin
            // R13: inputs returned on every accepted call
            resp_v_nxt = 1'b1;
            // R3: full four input bits in the answer
            resp_d_nxt = din_sync;
            if (split) begin
                last_i2_nxt = i2;
                if (joint) begin
                    // R8: I2 high holds, I2 low writes both banks
                    if (i2) begin
                        held_nxt = call_info_in[1:0];
                    end else begin
                        data_nxt = {call_info_in[1:0], held_r};
                    end
                end else if (i2) begin
                    // R4: inverted select, I2 high to D0/D1
                    data_nxt[1:0] = call_info_in[1:0];
                end else begin
                    // R9: only the selected bank changes
                    data_nxt[3:2] = call_info_in[1:0];
                end
            end else if (ext_mode) begin
                // R2: I3 is the select bit, D3 left alone
                data_nxt[2:0] = call_info_in[2:0];
            end else begin
                data_nxt = call_info_in;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            data_r    <= DATA_IDLE;
            held_r    <= 2'b00;
            last_i2_r <= 1'b0;
            resp_v_r  <= 1'b0;
            resp_d_r  <= 4'h0;
        end else begin
            data_r    <= data_nxt;
            held_r    <= held_nxt;
            last_i2_r <= last_i2_nxt;
            resp_v_r  <= resp_v_nxt;
            resp_d_r  <= resp_d_nxt;
        end
    end

    // Strobe generation and watchdog sequence
    always_comb begin
        wd_st_nxt   = wd_st_r;
        stb_cnt_nxt = stb_cnt_r;
        dstb_nxt    = dstb_r;
        pstb_nxt    = pstb_r;
        // External reset asks for initialisation in any sequence state
        nvm_nxt     = ext_expired;
        case (wd_st_r)
            ST_RUN: begin
                if (ext_expired) begin
                    dstb_nxt    = 1'b0;
                    pstb_nxt    = 1'b0;
                    stb_cnt_nxt = 8'h00;
                    nvm_nxt     = 1'b1;
                end else if (wd_expired) begin
                    // R11: both strobes before the reset
                    wd_st_nxt   = ST_STROBE;
                    dstb_nxt    = 1'b1;
                    pstb_nxt    = 1'b1;
                    stb_cnt_nxt = STROBE_LOAD;
                end else if (out_event) begin
                    // R6: strobe pulse with each output update
                    dstb_nxt    = 1'b1;
                    stb_cnt_nxt = STROBE_LOAD;
                end else if (stb_cnt_r > 8'h01) begin
                    stb_cnt_nxt = stb_cnt_r - 8'h01;
                end else begin
                    stb_cnt_nxt = 8'h00;
                    dstb_nxt    = 1'b0;
                end
            end
            ST_STROBE: begin
                if (stb_cnt_r > 8'h01) begin
                    stb_cnt_nxt = stb_cnt_r - 8'h01;
                end else begin
                    stb_cnt_nxt = 8'h00;
                    dstb_nxt    = 1'b0;
                    pstb_nxt    = 1'b0;
                    wd_st_nxt   = ST_RESET;
                end
            end
            ST_RESET: begin
                // R12: reset after strobes, then initialise
                wd_st_nxt = ST_RUN;
                nvm_nxt   = 1'b1;
            end
            default: begin
                wd_st_nxt   = ST_RUN;
                dstb_nxt    = 1'b0;
                pstb_nxt    = 1'b0;
                stb_cnt_nxt = 8'h00;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wd_st_r   <= ST_RUN;
            stb_cnt_r <= 8'h00;
            dstb_r    <= 1'b0;
            pstb_r    <= 1'b0;
            nvm_r     <= 1'b0;
        end else begin
            wd_st_r   <= wd_st_nxt;
            stb_cnt_r <= stb_cnt_nxt;
            dstb_r    <= dstb_nxt;
            pstb_r    <= pstb_nxt;
            nvm_r     <= nvm_nxt;
        end
    end

    // Wishbone decode: one wait state, ack for one cycle
    assign wb_req = wb_cyc_in && wb_stb_in && !ack_r;
    assign wb_wr  = wb_req && wb_we_in;
    assign irq_clr = (wb_wr && wb_adr_in == IRQ_CLEAR_OFS && wb_sel_in[0])
                     ? wb_dat_in[IRQ_W-1:0] : '0;
    assign irq_ev = {accept, ext_expired, wd_expired && (wd_st_r == ST_RUN), out_event};

    // Registers, interrupts and read mux
    always_comb begin
        ctrl_nxt    = ctrl_r;
        inhibit_nxt = inhibit_r;
        irq_en_nxt  = irq_en_r;
        ack_nxt     = wb_req;
        rdat_nxt    = 32'h0000_0000;
        if (wb_wr) begin
            case (wb_adr_in)
                CTRL_OFS: begin
                    if (wb_sel_in[0]) ctrl_nxt[7:0]  = wb_dat_in[7:0];
                    if (wb_sel_in[1]) ctrl_nxt[12:8] = wb_dat_in[12:8];
                end
                ACTIVATE_OFS: begin
                    if (wb_sel_in[0] && wb_dat_in[0]) inhibit_nxt = 1'b0;
                end
                IRQ_ENABLE_OFS: begin
                    if (wb_sel_in[0]) irq_en_nxt = wb_dat_in[IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end
        // Reset sets inhibit and wins over an activating write
        if (soft_reset) begin
            inhibit_nxt = 1'b1;
        end
        if (wb_req && !wb_we_in) begin
            case (wb_adr_in)
                CTRL_OFS:       rdat_nxt = {19'h0, ctrl_r};
                STATUS_OFS:     rdat_nxt = {22'h0, wd_st_r, armed, last_i2_r,
                                            held_r, data_r};
                ACTIVATE_OFS:   rdat_nxt = {31'h0, inhibit_r};
                IRQ_STATUS_OFS: rdat_nxt = {28'h0, irq_st_r};
                IRQ_ENABLE_OFS: rdat_nxt = {28'h0, irq_en_r};
                default:        rdat_nxt = 32'h0000_0000;
            endcase
        end
        // New events beat a simultaneous clear
        irq_st_nxt = (irq_st_r & ~irq_clr) | irq_ev;
        irq_nxt    = |(irq_st_nxt & irq_en_nxt);
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_r    <= CTRL_RESET;
            inhibit_r <= 1'b1;
            irq_st_r  <= '0;
            irq_en_r  <= '0;
            irq_r     <= 1'b0;
            ack_r     <= 1'b0;
            rdat_r    <= 32'h0000_0000;
        end else begin
            ctrl_r    <= ctrl_nxt;
            inhibit_r <= inhibit_nxt;
            irq_st_r  <= irq_st_nxt;
            irq_en_r  <= irq_en_nxt;
            irq_r     <= irq_nxt;
            ack_r     <= ack_nxt;
            rdat_r    <= rdat_nxt;
        end
    end

    // Outputs straight from flops; strobe pin pulled low only while active
    assign wb_ack_out           = ack_r;
    assign wb_dat_out           = rdat_r;
    assign resp_valid_out       = resp_v_r;
    assign resp_data_out        = resp_d_r;
    assign data_out_out         = data_r;
    assign data_strobe_n_out    = 1'b0;
    assign data_strobe_oe_n_out = !dstb_r;
    assign param_strobe_n_out   = !pstb_r;
    assign nvm_readout_out      = nvm_r;
    assign irq_out              = irq_r;

    // Checks on the block's own behaviour
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_joint_hold;
        accept && split && joint && i2 && !soft_reset && !wd_expired;
    endsequence

    // A strobe still running from an earlier event may continue; no new one starts
    a_joint_hold_quiet: assert property ( // R8
        s_joint_hold |=> $stable(data_out_out) && !$fell(data_strobe_oe_n_out))
        else $error("joint mode hold call changed outputs");

    a_joint_both_banks: assert property ( // R7
        accept && split && joint && !i2 && !soft_reset
        |=> data_out_out == {$past(call_info_in[1:0]), $past(held_r)})
        else $error("joint update did not load both banks");

    a_bank_one_only: assert property ( // R9
        accept && split && !joint && i2 && !soft_reset
        |=> data_out_out[1:0] == $past(call_info_in[1:0])
            && data_out_out[3:2] == $past(data_out_out[3:2]))
        else $error("separate update touched wrong bank");

    a_event_strobe: assert property ( // R6
        out_event && !soft_reset |=> !data_strobe_oe_n_out [*2])
        else $error("output event without strobe pulse");

    a_three_bits: assert property ( // R2
        accept && ext_mode && !split && !soft_reset |=> $stable(data_out_out[3]))
        else $error("fourth output bit changed without split mode");

    a_resp_every: assert property ( // R13
        accept && !soft_reset |=> resp_valid_out && resp_data_out == $past(din_sync))
        else $error("accepted call not answered with inputs");

    a_ab_select: assert property ( // R1
        call_valid_in && ext_mode && (call_info_in[3] != ctrl_r[CTRL_AB_SEL])
        |=> !resp_valid_out)
        else $error("call for other A/B slave was answered");

    a_wd_strobes: assert property ( // R11
        wd_expired && wd_st_r == ST_RUN && !ext_expired
        |=> !param_strobe_n_out && !data_strobe_oe_n_out)
        else $error("watchdog expiry without both strobes");

    a_reset_inhibit: assert property ( // R12
        wd_st_r == ST_RESET |=> inhibit_r && data_out_out == DATA_IDLE && nvm_readout_out)
        else $error("watchdog reset did not inhibit and clear");

    a_ext_reset: assert property ( // R14
        ext_expired |=> inhibit_r && nvm_readout_out)
        else $error("external reset did not take effect");

    a_wd_disarm: assert property ( // R10
        !armed && wd_st_r == ST_RUN |=> wd_st_r != ST_STROBE)
        else $error("watchdog fired while not armed");
endmodule
`default_nettype wire

// file: bench/call_master.sv
// Field bus master model issuing data exchange calls
`default_nettype none
module call_master (
    // Clock
    input  wire logic       clk_in,
    // Call towards the slave
    output logic            call_valid_out,
    output logic      [3:0] call_info_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        call_valid_out = 1'b0;
        call_info_out  = 4'h0;
    end
    task automatic send(input logic [3:0] info);
        @(posedge clk_in);
        call_valid_out <= 1'b1;
        call_info_out  <= info;
        @(posedge clk_in);
        call_valid_out <= 1'b0;
        call_info_out  <= ~info; // Stale info inverted, never reused by mistake
    endtask
endmodule
`default_nettype wire

// file: bench/ext_addr_split_output_bank_tb.sv
// Self-checking bench for the split output bank block
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module ext_addr_split_output_bank_tb
    import bank_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ext_low = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, wb_dat_out;
    logic [3:0]  data_in = 4'h5, call_info, resp_data, data_out;
    logic        wb_ack_out, call_valid, resp_valid, oe_n, pstb_n, irq_out, dso, nvm;
    int          n_errors = 0, checked = 0, cycles = 0, n_nvm = 0;
    // Pulled-up strobe pin, low while anyone pulls it
    wire         pin = !(ext_low || (!oe_n && !dso));
    always #25 core_clk_in = ~core_clk_in;
    call_master u_m (.clk_in(core_clk_in), .call_valid_out(call_valid),
        .call_info_out(call_info));
    ext_addr_split_output_bank #(.WD_LIMIT(50), .EXT_LIMIT(30)) u_dut (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'h3), .wb_dat_in(wdat),
        .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .call_valid_in(call_valid),
        .call_info_in(call_info), .resp_valid_out(resp_valid), .resp_data_out(resp_data),
        .data_in_in(data_in), .data_out_out(data_out), .data_strobe_n_in(pin),
        .data_strobe_n_out(dso), .data_strobe_oe_n_out(oe_n), .param_strobe_n_out(pstb_n),
        .nvm_readout_out(nvm), .irq_out(irq_out));
    // Classic single cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do @(posedge core_clk_in); while (wb_ack_out !== 1'b1);
        rdat = wb_dat_out;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic call(input logic [3:0] i, input logic v, input logic [3:0] d);
        u_m.send(i);
        #1;
        `CHK(resp_valid, v)
        `CHK(data_out, d)
    endtask
    task automatic t_regs;
        `CHK(data_out, 4'h0)
        wb(1'b1, CTRL_OFS, 32'h0503);
        wb(1'b1, IRQ_ENABLE_OFS, 32'hf);
        wb(1'b1, ACTIVATE_OFS, 32'h1);
        wb(1'b0, CTRL_OFS, 32'h0);
        `CHK(rdat, 32'h0503)
        wb(1'b0, 8'h40, 32'h0);
        `CHK(rdat, 32'h0)
    endtask
    task automatic t_split;
        call(4'h6, 1'b1, 4'h2);
        `CHK(resp_data, 4'h5)
        `CHK(oe_n, 1'b0)
        `CHK(dso, 1'b0)
        call(4'h1, 1'b1, 4'h6);
    endtask
    task automatic t_joint;
        wb(1'b1, CTRL_OFS, 32'h0507);
        repeat (45) @(posedge core_clk_in);
        call(4'h5, 1'b1, 4'h6);
        `CHK(oe_n, 1'b1)
        call(4'h2, 1'b1, 4'h9);
        `CHK(resp_data, 4'h5)
        call(4'hd, 1'b0, 4'h9);
        wb(1'b1, CTRL_OFS, 32'h0501);
        call(4'h6, 1'b1, 4'he);
    endtask
    task automatic t_irq;
        `CHK(irq_out, 1'b1)
        wb(1'b0, IRQ_STATUS_OFS, 32'h0);
        `CHK(rdat[3:0], 4'h9)
        wb(1'b1, IRQ_CLEAR_OFS, 32'hf);
        wb(1'b1, IRQ_ENABLE_OFS, 32'h0);
        call(4'h6, 1'b1, 4'he);
        repeat (2) @(posedge core_clk_in);
        `CHK(irq_out, 1'b0)
        wb(1'b1, IRQ_ENABLE_OFS, 32'hf);
        repeat (2) @(posedge core_clk_in);
        `CHK(irq_out, 1'b1)
    endtask
    task automatic t_wd;
        // Address zero keeps the watchdog quiet
        wb(1'b1, CTRL_OFS, 32'h000b);
        repeat (100) @(posedge core_clk_in);
        `CHK(pstb_n, 1'b1)
        // Busy nonvolatile write also keeps it quiet
        wb(1'b1, CTRL_OFS, 32'h051b);
        wb(1'b0, STATUS_OFS, 32'h0);
        `CHK(rdat[7], 1'b0)
        repeat (100) @(posedge core_clk_in);
        `CHK(pstb_n, 1'b1)
        wb(1'b1, CTRL_OFS, 32'h050b);
        wb(1'b0, STATUS_OFS, 32'h0);
        `CHK(rdat[7], 1'b1)
        for (int i = 0; i < 6; i++) begin
            u_m.send({1'b0, i[0], 2'h3});
            repeat (30) @(posedge core_clk_in);
        end
        `CHK(pstb_n, 1'b1)
        for (int i = 0; i < 100 && pstb_n !== 1'b0; i++) @(posedge core_clk_in);
        #1;
        `CHK(pstb_n, 1'b0)
        `CHK(oe_n, 1'b0)
        repeat (60) @(posedge core_clk_in);
        `CHK(data_out, 4'h0)
        `CHK(n_nvm, 1)
        wb(1'b0, ACTIVATE_OFS, 32'h0);
        `CHK(rdat[0], 1'b1)
        call(4'h6, 1'b0, 4'h0);
    endtask
    task automatic t_ext;
        wb(1'b1, CTRL_OFS, 32'h0503);
        wb(1'b1, ACTIVATE_OFS, 32'h1);
        call(4'h7, 1'b1, 4'h3);
        repeat (45) @(posedge core_clk_in);
        ext_low <= 1'b1;
        repeat (20) @(posedge core_clk_in);
        ext_low <= 1'b0;
        repeat (5) @(posedge core_clk_in);
        `CHK(data_out, 4'h3)
        ext_low <= 1'b1;
        repeat (40) @(posedge core_clk_in);
        ext_low <= 1'b0;
        repeat (5) @(posedge core_clk_in);
        `CHK(data_out, 4'h0)
        wb(1'b0, IRQ_STATUS_OFS, 32'h0);
        `CHK(rdat[2], 1'b1)
        `CHK((n_nvm > 1), 1'b1)
        // Plain addressing: I3 is data, no A/B match
        wb(1'b1, CTRL_OFS, 32'h0000);
        wb(1'b1, ACTIVATE_OFS, 32'h1);
        call(4'hd, 1'b1, 4'hd);
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Hang guard, far above the under a thousand cycles needed
    always @(posedge core_clk_in) begin
        cycles++;
        // Count initialisation cycles here; watchdog pulses last one cycle, external ones as long as the reset holds
        if (nvm === 1'b1) n_nvm++;
        if (cycles == 20000) begin
            n_errors++;
            print_verdict();
        end
    end
    initial begin
        repeat (20) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        @(posedge core_clk_in);
        t_regs();
        t_split();
        t_joint();
        t_irq();
        t_wd();
        t_ext();
        print_verdict();
    end
endmodule
`default_nettype wire
